// >>> core/dto_observe_mux.sv
// Digital test observation multiplexer with its byte-wide select register
//
// Behaviour
// - Byte register at special-function address 0xEA, read-write, cleared on reset.
// - Bits 4 to 0 form one selection code steering the observation pins.
// - Code 01 routes saturation enable, finished and comparator output.
// - Code 04 routes serial receive to test pin, transmit to pin two.
// - Code 08 routes FIFO write pointer update pulse to test pin.
// - Code 0A routes a half-rate system clock toggle, internal and external clocks.
`timescale 1ns/10ps
module dto_observe_mux
  import dto_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_saturation_enable,
  input wire logic i_saturation_finished,
  input wire logic i_saturation_comparator_out,
  input wire logic i_serial_rx,
  input wire logic i_serial_tx,
  input wire logic i_fifo_wr_ptr_update,
  input wire logic i_internal_osc_clock,
  input wire logic i_external_input_clock,
  input dto_pkg::dto_pin_s i_test_func,
  input dto_pkg::dto_pin_s i_gp1_func,
  input dto_pkg::dto_pin_s i_gp2_func,
  output dto_pkg::dto_pin_s o_digital_test_out_pin,
  output dto_pkg::dto_pin_s o_general_pin_one,
  output dto_pkg::dto_pin_s o_general_pin_two
);
  import dto_pkg::*;

  // ****************************************
  // Select register and read port
  // ****************************************
  logic [7:0] probe_select;
  logic [7:0] next_probe_select;
  logic [7:0] next_rdata;
  logic [4:0] probe_select_code;
  logic addr_hit;

  assign addr_hit = (i_sfr_addr == DTO_PROBE_SELECT_ADDR);
  assign probe_select_code = probe_select[DTO_CODE_MSB:DTO_CODE_LSB];

  always_comb begin
    next_probe_select = probe_select;
    if (i_rst) begin
      next_probe_select = DTO_PROBE_SELECT_RESET;
    end else if (i_sfr_wr && addr_hit) begin
      next_probe_select = i_sfr_wdata;
    end
    next_rdata = addr_hit ? probe_select : DTO_UNMAPPED_READ;
    if (i_rst) begin
      next_rdata = DTO_UNMAPPED_READ;
    end
  end

  always_ff @(posedge i_clk) begin
    probe_select <= next_probe_select;
    o_sfr_rdata <= next_rdata;
  end

  // ****************************************
  // Foreign clocks into the system domain
  // ****************************************
  logic [1:0] int_sync;
  logic [1:0] ext_sync;
  logic sys_toggle;
  logic [1:0] next_int_sync;
  logic [1:0] next_ext_sync;
  logic next_sys_toggle;

  always_comb begin
    next_int_sync = {int_sync[0], i_internal_osc_clock};
    next_ext_sync = {ext_sync[0], i_external_input_clock};
    next_sys_toggle = i_rst ? 1'b0 : ~sys_toggle;
  end

  always_ff @(posedge i_clk) begin
    int_sync <= next_int_sync;
    ext_sync <= next_ext_sync;
    sys_toggle <= next_sys_toggle;
  end

  // ****************************************
  // Observation routing
  // ****************************************
  dto_pin_s next_test;
  dto_pin_s next_gp1;
  dto_pin_s next_gp2;

  always_comb begin
    next_test = i_test_func;
    next_gp1 = i_gp1_func;
    next_gp2 = i_gp2_func;
    if (i_rst) begin
      next_test = '0;
      next_gp1 = '0;
      next_gp2 = '0;
    end else begin
      case (probe_select_code)
        DTO_SEL_SATURATION: begin
          next_test = '{val: i_saturation_enable, oe: 1'b1};
          next_gp1 = '{val: i_saturation_finished, oe: 1'b1};
          next_gp2 = '{val: i_saturation_comparator_out, oe: 1'b1};
        end
        DTO_SEL_SERIAL: begin
          next_test = '{val: i_serial_rx, oe: 1'b1};
          next_gp2 = '{val: i_serial_tx, oe: 1'b1};
        end
        DTO_SEL_FIFO: begin
          next_test = '{val: i_fifo_wr_ptr_update, oe: 1'b1};
        end
        DTO_SEL_CLOCKS: begin
          next_test = '{val: sys_toggle, oe: 1'b1};
          next_gp1 = '{val: int_sync[1], oe: 1'b1};
          next_gp2 = '{val: ext_sync[1], oe: 1'b1};
        end
        default: begin
          next_test = i_test_func;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    o_digital_test_out_pin <= next_test;
    o_general_pin_one <= next_gp1;
    o_general_pin_two <= next_gp2;
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_reset_clears;
    @(posedge i_clk) i_rst |=> (probe_select == 8'h00);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("select not cleared");

  property p_write_read;
    @(posedge i_clk) disable iff (i_rst)
      (i_sfr_wr && addr_hit) ##1 (addr_hit && !i_sfr_wr)
      |=> (o_sfr_rdata == $past(i_sfr_wdata, 2));
  endproperty
  a_write_read: assert property (p_write_read) else $error("readback mismatch");

  property p_code_field;
    @(posedge i_clk) disable iff (i_rst)
      (i_sfr_wr && addr_hit) |=> (probe_select_code == $past(i_sfr_wdata[4:0]));
  endproperty
  a_code_field: assert property (p_code_field) else $error("code field wrong");

  property p_saturation;
    @(posedge i_clk) disable iff (i_rst)
      (probe_select_code == 5'h01) |=> (o_digital_test_out_pin.val == $past(i_saturation_enable)
      && o_general_pin_one.val == $past(i_saturation_finished)
      && o_general_pin_two.val == $past(i_saturation_comparator_out)
      && o_general_pin_two.oe);
  endproperty
  a_saturation: assert property (p_saturation) else $error("saturation route wrong");

  property p_serial;
    @(posedge i_clk) disable iff (i_rst)
      (probe_select_code == 5'h04) |=> (o_digital_test_out_pin.val == $past(i_serial_rx)
      && o_general_pin_two.val == $past(i_serial_tx) && o_general_pin_one == $past(i_gp1_func));
  endproperty
  a_serial: assert property (p_serial) else $error("serial route wrong");

  property p_fifo;
    @(posedge i_clk) disable iff (i_rst)
      (probe_select_code == 5'h08) |=> (o_digital_test_out_pin.val == $past(i_fifo_wr_ptr_update)
      && o_general_pin_two == $past(i_gp2_func));
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo route wrong");

  property p_clocks;
    @(posedge i_clk) disable iff (i_rst)
      (probe_select_code == 5'h0a) [*2]
      |=> (o_digital_test_out_pin.val != $past(o_digital_test_out_pin.val)
      && o_general_pin_one.val == $past(i_internal_osc_clock, 3));
  endproperty
  a_clocks: assert property (p_clocks) else $error("clock route wrong");

  property p_functional;
    @(posedge i_clk) disable iff (i_rst)
      !(probe_select_code inside {5'h01, 5'h04, 5'h08, 5'h0a})
      |=> (o_digital_test_out_pin == $past(i_test_func) && o_general_pin_one == $past(i_gp1_func));
  endproperty
  a_functional: assert property (p_functional) else $error("idle pins not functional");

  property p_reset_pins;
    @(posedge i_clk) i_rst |=> (o_digital_test_out_pin == '0
      && o_general_pin_one == '0 && o_general_pin_two == '0);
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins not quiet in reset");

  property p_unmapped_read;
    @(posedge i_clk) disable iff (i_rst)
      !addr_hit |=> (o_sfr_rdata == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_upper_bits;
    @(posedge i_clk) disable iff (i_rst)
      (i_sfr_wr && addr_hit) |=> (probe_select[7:5] == $past(i_sfr_wdata[7:5]));
  endproperty
  a_upper_bits: assert property (p_upper_bits) else $error("upper bits not stored");

  property p_saturation_oe;
    @(posedge i_clk) disable iff (i_rst)
      (probe_select_code == 5'h01) |=> (o_digital_test_out_pin.oe && o_general_pin_one.oe);
  endproperty
  a_saturation_oe: assert property (p_saturation_oe) else $error("saturation pins not driven");

  property p_fifo_gp1;
    @(posedge i_clk) disable iff (i_rst)
      (probe_select_code == 5'h08) |=> (o_general_pin_one == $past(i_gp1_func)
      && o_digital_test_out_pin.oe);
  endproperty
  a_fifo_gp1: assert property (p_fifo_gp1) else $error("fifo pin one not functional");

  property p_clock_ext;
    @(posedge i_clk) disable iff (i_rst)
      (probe_select_code == 5'h0a) [*2]
      |=> (o_general_pin_two.val == $past(i_external_input_clock, 3)
      && o_digital_test_out_pin.oe && o_general_pin_one.oe && o_general_pin_two.oe);
  endproperty
  a_clock_ext: assert property (p_clock_ext) else $error("external clock route wrong");
endmodule

// >>> core/dto_pkg.sv
// Constants and types for the digital test observation multiplexer
package dto_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] DTO_PROBE_SELECT_ADDR = 8'hea;
  localparam logic [7:0] DTO_PROBE_SELECT_RESET = 8'h00;
  localparam int DTO_CODE_LSB = 0;
  localparam int DTO_CODE_MSB = 4;
  localparam logic [7:0] DTO_UNMAPPED_READ = 8'h00;

  // ****************************************
  // Selection codes
  // ****************************************
  typedef enum logic [4:0] {
    DTO_SEL_NONE = 5'h00,
    DTO_SEL_SATURATION = 5'h01,
    DTO_SEL_SERIAL = 5'h04,
    DTO_SEL_FIFO = 5'h08,
    DTO_SEL_CLOCKS = 5'h0a
  } dto_sel_e;

  // ****************************************
  // Pin drive
  // ****************************************
  typedef struct packed {
    logic val;
    logic oe;
  } dto_pin_s;
endpackage

// >>> verif/dto_probe.sv
// Bench probe watching one observation pin
`timescale 1ns/10ps
module dto_probe
  import dto_pkg::*;
(
  input dto_pkg::dto_pin_s i_pin,
  output logic o_level
);
  // Released pin rests high through the pull-up
  assign o_level = i_pin.oe ? i_pin.val : 1'b1;
endmodule

// >>> verif/tb.sv
// Self-checking bench for the observation multiplexer
`timescale 1ns/10ps
module tb;
  import dto_pkg::*;
  logic i_clk = 0;
  logic i_rst = 1;
  logic wr = 0;
  logic [7:0] addr = 8'hea;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [13:0] v = '0;
  logic [41:0] hist = '0;
  logic [31:0] seed = 32'd42;
  logic [31:0] r;
  logic [7:0] d;
  logic lvl;
  logic prev = 0;
  dto_pin_s tp, g1, g2;
  int fail_count = 0;
  int n_tests = 0;
  logic [4:0] codes [8] = '{5'h00, 5'h01, 5'h04, 5'h08, 5'h0a, 5'h1f, 5'h02, 5'h0b};

  dto_observe_mux dto_observe_mux_inst (.i_clk(i_clk), .i_rst(i_rst), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_saturation_enable(v[0]),
    .i_saturation_finished(v[1]), .i_saturation_comparator_out(v[2]), .i_serial_rx(v[3]),
    .i_serial_tx(v[4]), .i_fifo_wr_ptr_update(v[5]), .i_internal_osc_clock(v[6]),
    .i_external_input_clock(v[7]), .i_test_func(v[9:8]), .i_gp1_func(v[11:10]),
    .i_gp2_func(v[13:12]), .o_digital_test_out_pin(tp), .o_general_pin_one(g1),
    .o_general_pin_two(g2));
  dto_probe dto_probe_inst (.i_pin(tp), .o_level(lvl));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [5:0] expect_pins(logic [4:0] c, logic [13:0] a, logic [13:0] b);
    logic [5:0] e;
    e = {a[9:8], a[11:10], a[13:12]};
    case (c)
      5'h01: e = {a[0], 1'b1, a[1], 1'b1, a[2], 1'b1};
      5'h04: e = {a[3], 1'b1, a[11:10], a[4], 1'b1};
      5'h08: e = {a[5], 1'b1, a[11:10], a[13:12]};
      5'h0a: e = {2'b00, b[6], 1'b1, b[7], 1'b1};
      default: e = e;
    endcase
    return e;
  endfunction

  task automatic chk(string name, logic [7:0] e, logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wreg(logic [7:0] data);
    @(negedge i_clk);
    addr = 8'hea;
    wdata = data;
    wr = 1;
    @(negedge i_clk);
    wr = 0;
  endtask

  task automatic rreg(logic [7:0] a, logic [7:0] e);
    @(negedge i_clk);
    addr = a;
    @(negedge i_clk);
    chk("rdata", e, rdata);
  endtask

  task automatic tick(bit on, logic [4:0] c);
    logic [5:0] e;
    @(negedge i_clk);
    e = expect_pins(c, hist[13:0], hist[41:28]);
    if (on) begin
      if (c == 5'h0a) chk("sys_clk", 8'h03, {6'h00, lvl != prev, tp.oe});
      else chk("test_pin", {6'h00, e[5:4]}, {6'h00, tp});
      chk("gp1", {6'h00, e[3:2]}, {6'h00, g1});
      chk("gp2", {6'h00, e[1:0]}, {6'h00, g2});
    end
    prev = lvl;
    r = rnd();
    v = r[13:0];
    hist = {hist[27:0], v};
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    repeat (10) @(negedge i_clk);
    i_rst = 0;
    rreg(DTO_PROBE_SELECT_ADDR, DTO_PROBE_SELECT_RESET);
    rreg(8'he9, DTO_UNMAPPED_READ);
    foreach (codes[i]) begin
      r = rnd();
      d = {r[7:5], codes[i]};
      wreg(d);
      rreg(8'hea, d);
      repeat (4) tick(0, codes[i]);
      repeat (30) tick(1, codes[i]);
    end
    // Reset in mid-run must drop a live clock route
    wreg(8'hea);
    @(negedge i_clk);
    i_rst = 1;
    repeat (3) @(negedge i_clk);
    chk("rst_pins", 8'h00, {2'b00, tp, g1, g2});
    i_rst = 0;
    rreg(8'hea, DTO_PROBE_SELECT_RESET);
    repeat (4) tick(0, 5'h00);
    repeat (8) tick(1, 5'h00);
    stop_test();
  end
endmodule
